// file: inc/htc_map.vh
`ifndef HTC_MAP_VH
`define HTC_MAP_VH

// ==========================================================
// Register offsets (word index on the plain register port)
`define HTC_OFS_CTRL    4'h0
`define HTC_OFS_TOP     4'h1
`define HTC_OFS_CMP     4'h2
`define HTC_OFS_COUNT   4'h3
`define HTC_OFS_CAPT    4'h4
`define HTC_OFS_STAT    4'h5
`define HTC_OFS_CLR     4'h6
`define HTC_OFS_IRQEN   4'h7
`define HTC_OFS_WAKEEN  4'h8

// ==========================================================
// Control register fields
`define HTC_F_MODE_LO   0
`define HTC_F_MODE_HI   1
`define HTC_F_DOWN      2
`define HTC_F_SRC       3
`define HTC_F_PRE_LO    4
`define HTC_F_PRE_HI    6
`define HTC_F_CAPEN     7
`define HTC_F_RPEN      8
`define HTC_F_RUN       9
`define HTC_F_OCA_LO    10
`define HTC_F_OCA_HI    11

// ==========================================================
// Operating modes
`define HTC_MODE_WDOG   2'h0
`define HTC_MODE_CTC    2'h1
`define HTC_MODE_FPWM   2'h2
`define HTC_MODE_PFC    2'h3

// ==========================================================
// Output compare actions (non-PWM) / inversion (PWM, bit 0)
`define HTC_OCA_NONE    2'h0
`define HTC_OCA_TOGGLE  2'h1
`define HTC_OCA_CLEAR   2'h2
`define HTC_OCA_SET     2'h3

// ==========================================================
// Status bits
`define HTC_ST_OVF      0
`define HTC_ST_MATCH    1
`define HTC_ST_CAPT     2

// ==========================================================
// Reset values
`define HTC_RST_CTRL    16'h0100
`define HTC_RST_TOP     16'hFFFF
`define HTC_RST_CMP     16'h8000
`define HTC_RST_MASK    3'h0

// ==========================================================
// Prescaler selections, divide ratio minus one
`define HTC_PRE_DIV1    10'h000
`define HTC_PRE_DIV8    10'h007
`define HTC_PRE_DIV64   10'h03F
`define HTC_PRE_DIV256  10'h0FF
`define HTC_PRE_DIV1024 10'h3FF

`endif

// file: core/htc_prescale.v
`timescale 1ns/100ps
`include "htc_map.vh"

// ==========================================================
// Prescaler: turns the chosen source events into count ticks
module htc_prescale (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // Source selection and events
  input  wire       src_ext,
  input  wire       ext_rise,
  input  wire [2:0] pre_sel,
  input  wire       run,
  // Count tick
  output reg        tick
);

  reg  [9:0] div_cnt;    // Events seen in the current division
  reg  [9:0] div_last;   // Terminal value of the division
  wire       src_event;  // One source event this cycle

  // Source: every system clock, or a sampled timer clock edge
  assign src_event = run & (src_ext ? ext_rise : 1'b1);

  // Decode of the divide ratio
  always @* begin
    case (pre_sel)
      3'h0:    div_last = `HTC_PRE_DIV1;
      3'h1:    div_last = `HTC_PRE_DIV8;
      3'h2:    div_last = `HTC_PRE_DIV64;
      3'h3:    div_last = `HTC_PRE_DIV256;
      3'h4:    div_last = `HTC_PRE_DIV1024;
      default: div_last = `HTC_PRE_DIV1;
    endcase
  end

  // Divider; a stopped timer restarts with a fresh division
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 10'h000;
      tick    <= 1'b0;
    end else if (!run) begin
      div_cnt <= 10'h000;
      tick    <= 1'b0;
    end else if (src_event) begin
      if (div_cnt >= div_last) begin
        div_cnt <= 10'h000;
        tick    <= 1'b1;
      end else begin
        div_cnt <= div_cnt + 10'h001;
        tick    <= 1'b0;
      end
    end else begin
      tick <= 1'b0;
    end
  end

endmodule

// file: core/htc_top.v
// Operation
// (RQ1) 16-bit counter counting up or down
// (RQ2) Independent compare unit plus PWM generation
// (RQ3) Watchdog, clear-on-match, fast PWM, PFC PWM
// (RQ4) Selectable count source through programmable prescaler
// (RQ5) One static routed interrupt output
// (RQ6) Separate wake-up interrupt to standby controller
// (RQ7) Overflow, compare match, capture interrupt sources
// (RQ8) Glitch-free PWM with variable period
// (RQ9) Waveform driven on compare output pin
// (RQ10) Registers reached by bus master access
// (RQ11) Stand-alone mode: preloaded controls, direct reset
// (RQ12) Reset pin enable preloaded as enabled
// (RQ13) Counts on dedicated timer input clock
// (RQ14) Capture only non-PWM and bus mode
// (RQ15) Synchronised rising edge captures count value
// (RQ16) Without bus, interrupt is overflow flag
// (RQ17) With bus, interrupt gated by IRQ registers
// (RQ18) Counter reloads automatically each period
// (RQ19) PFC counts up then down, symmetric output
`timescale 1ns/100ps
`include "htc_map.vh"

module htc_top #(
  parameter [15:0] PRELOAD_CTRL = 16'h0300,  // Stand-alone control value
  parameter [15:0] PRELOAD_TOP  = 16'hFFFF,  // Stand-alone period
  parameter [15:0] PRELOAD_CMP  = 16'h8000   // Stand-alone compare
) (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst_n,
  // Register port
  input  wire [3:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  // Operating mode: high when a bus master runs the block
  input  wire        bus_enable,
  // Pins
  input  wire        timer_clock_in,
  input  wire        timer_reset_n_pin,
  input  wire        capture_trigger,
  // Results
  output reg         compare_output,
  output reg         timer_irq,
  output reg         wake_irq
);

  // ==========================================================
  // Reset release and pin synchronisers
  reg        rst_s1;          // First reset release stage
  reg        rst_s2;          // Released reset used by the design
  reg  [1:0] tclk_sync;       // Timer clock pin synchroniser
  reg        tclk_prev;       // Previous synchronised timer clock
  reg  [1:0] trst_sync;       // Reset pin synchroniser
  reg  [1:0] cap_sync;        // Capture pin synchroniser
  reg        cap_prev;        // Previous synchronised capture level

  // Reset released through two flops
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  // Pins pass two flops; edge detection looks at the second only
  always @(posedge ref_clk or negedge rst_s2) begin
    if (!rst_s2) begin
      tclk_sync <= 2'h0;
      tclk_prev <= 1'b0;
      trst_sync <= 2'h3;
      cap_sync  <= 2'h0;
      cap_prev  <= 1'b0;
    end else begin
      tclk_sync <= {tclk_sync[0], timer_clock_in};
      tclk_prev <= tclk_sync[1];
      trst_sync <= {trst_sync[0], timer_reset_n_pin};
      cap_sync  <= {cap_sync[0], capture_trigger};  // [RQ15]
      cap_prev  <= cap_sync[1];
    end
  end

  wire tclk_rise = tclk_sync[1] & ~tclk_prev;  // Timer clock edge [RQ13]
  wire cap_rise  = cap_sync[1] & ~cap_prev;    // Capture edge [RQ15]

  // ==========================================================
  // Register storage
  reg  [15:0] ctrl_reg;     // Control register
  reg  [15:0] top_reg;      // Period, as written
  reg  [15:0] cmp_reg;      // Compare, as written
  reg  [15:0] top_act;      // Period in force
  reg  [15:0] cmp_act;      // Compare in force
  reg  [15:0] count_value;  // The counter
  reg  [15:0] capture_register;  // Time stamp of last capture
  reg  [2:0]  status;       // Sticky event flags
  reg  [2:0]  irq_en;       // Routed interrupt enables
  reg  [2:0]  wake_en;      // Wake-up interrupt enables
  reg         count_up;     // PFC direction, high while rising

  // Effective control: preloaded values when no bus runs the block
  wire [15:0] ctrl_eff = bus_enable ? ctrl_reg : PRELOAD_CTRL;  // [RQ11]
  wire [15:0] top_src  = bus_enable ? top_reg : PRELOAD_TOP;
  wire [15:0] cmp_src  = bus_enable ? cmp_reg : PRELOAD_CMP;

  wire [1:0] mode     = ctrl_eff[`HTC_F_MODE_HI:`HTC_F_MODE_LO];  // [RQ3]
  wire       dir_down = ctrl_eff[`HTC_F_DOWN];
  wire       src_ext  = ctrl_eff[`HTC_F_SRC];
  wire [2:0] pre_sel  = ctrl_eff[`HTC_F_PRE_HI:`HTC_F_PRE_LO];
  wire       cap_en   = ctrl_eff[`HTC_F_CAPEN];
  wire       run      = ctrl_eff[`HTC_F_RUN];
  wire [1:0] oc_act   = ctrl_eff[`HTC_F_OCA_HI:`HTC_F_OCA_LO];
  wire       pwm_mode = mode[1];

  // The reset pin enable is always set in stand-alone use
  wire rpin_en = bus_enable ? ctrl_reg[`HTC_F_RPEN] : 1'b1;  // [RQ12]

  // Timer-local reset from the pin, gated by its enable
  wire pin_reset = rpin_en & ~trst_sync[1];  // [RQ11]

  // Bus access decode
  wire wr_ctrl  = reg_wr & bus_enable & (reg_addr == `HTC_OFS_CTRL);   // [RQ10]
  wire wr_top   = reg_wr & bus_enable & (reg_addr == `HTC_OFS_TOP);
  wire wr_cmp   = reg_wr & bus_enable & (reg_addr == `HTC_OFS_CMP);
  wire wr_count = reg_wr & bus_enable & (reg_addr == `HTC_OFS_COUNT);
  wire wr_clr   = reg_wr & bus_enable & (reg_addr == `HTC_OFS_CLR);
  wire wr_irqen = reg_wr & bus_enable & (reg_addr == `HTC_OFS_IRQEN);
  wire wr_wake  = reg_wr & bus_enable & (reg_addr == `HTC_OFS_WAKEEN);

  // ==========================================================
  // Prescaler
  wire tick;  // One count step

  htc_prescale u_pre (
    .clk      (ref_clk),
    .rst_n    (rst_s2),
    .src_ext  (src_ext),
    .ext_rise (tclk_rise),
    .pre_sel  (pre_sel),
    .run      (run & ~pin_reset),
    .tick     (tick)
  );  // [RQ4]

  // ==========================================================
  // Count sequencing
  reg  [15:0] next_count;   // Counter after this tick
  reg         next_up;      // PFC direction after this tick
  reg         ovf_ev;       // Period end reached
  reg         next_oc;      // Compare output after this tick
  wire [15:0] limit   = (mode == `HTC_MODE_WDOG) ? 16'hFFFF : top_act;
  wire        match   = (count_value == cmp_act);
  wire        cap_ev  = cap_rise & cap_en & bus_enable & ~pwm_mode;  // [RQ14]

  // Next count, overflow and waveform for one tick
  always @* begin
    next_count = count_value;
    next_up    = count_up;
    ovf_ev     = 1'b0;
    next_oc    = compare_output;
    case (mode)
      `HTC_MODE_WDOG, `HTC_MODE_CTC: begin
        if (dir_down) begin
          // Down count reloads the limit at zero [RQ1] [RQ18]
          if (count_value == 16'h0000) begin
            next_count = limit;
            ovf_ev     = 1'b1;
          end else begin
            next_count = count_value - 16'h0001;
          end
        end else begin
          // Up count clears at the limit [RQ1] [RQ18]
          if (count_value >= limit) begin
            next_count = 16'h0000;
            ovf_ev     = 1'b1;
          end else begin
            next_count = count_value + 16'h0001;
          end
        end
        // Compare unit acts on its own [RQ2] [RQ9]
        if (match) begin
          case (oc_act)
            `HTC_OCA_TOGGLE: next_oc = ~compare_output;
            `HTC_OCA_CLEAR:  next_oc = 1'b0;
            `HTC_OCA_SET:    next_oc = 1'b1;
            default:         next_oc = compare_output;
          endcase
        end
      end
      `HTC_MODE_FPWM: begin
        // Sawtooth up to the period, output high from bottom to match
        if (count_value >= top_act) begin
          next_count = 16'h0000;
          ovf_ev     = 1'b1;
          next_oc    = ~oc_act[0];  // [RQ9]
        end else begin
          next_count = count_value + 16'h0001;
          if (match) begin
            next_oc = oc_act[0];  // [RQ2]
          end
        end
      end
      `HTC_MODE_PFC: begin
        // Triangle: up to the period, down to zero [RQ19]
        if (count_up) begin
          if (count_value >= top_act) begin
            next_up    = 1'b0;
            next_count = count_value - 16'h0001;
          end else begin
            next_count = count_value + 16'h0001;
          end
        end else begin
          if (count_value == 16'h0000) begin
            next_up    = 1'b1;
            next_count = 16'h0001;
            ovf_ev     = 1'b1;
          end else begin
            next_count = count_value - 16'h0001;
          end
        end
        // Clear on the way up, set on the way down [RQ19]
        if (match) begin
          next_oc = count_up ? oc_act[0] : ~oc_act[0];
        end
      end
      default: begin
        next_count = count_value;
      end
    endcase
  end

  // Counter, direction, output and the period/compare in force
  always @(posedge ref_clk or negedge rst_s2) begin
    if (!rst_s2) begin
      count_value    <= 16'h0000;
      count_up       <= 1'b1;
      compare_output <= 1'b0;
      top_act        <= `HTC_RST_TOP;
      cmp_act        <= `HTC_RST_CMP;
    end else if (pin_reset) begin
      count_value    <= 16'h0000;
      count_up       <= 1'b1;
      compare_output <= 1'b0;
      top_act        <= top_src;
      cmp_act        <= cmp_src;
    end else begin
      if (wr_count) begin
        count_value <= reg_wdata;
      end else if (tick) begin
        count_value    <= next_count;
        count_up       <= next_up;
        compare_output <= next_oc;  // [RQ9]
      end
      // A running PWM takes new values only at the period end, so no
      // partial period can shorten or split a pulse [RQ8]
      if (!pwm_mode || !run || (tick && ovf_ev)) begin
        top_act <= top_src;
        cmp_act <= cmp_src;
      end
    end
  end

  // ==========================================================
  // Capture register
  always @(posedge ref_clk or negedge rst_s2) begin
    if (!rst_s2) begin
      capture_register <= 16'h0000;
    end else if (cap_ev) begin
      capture_register <= count_value;  // [RQ15]
    end
  end

  // ==========================================================
  // Control registers written by the bus master
  always @(posedge ref_clk or negedge rst_s2) begin
    if (!rst_s2) begin
      ctrl_reg <= `HTC_RST_CTRL;  // Reset pin enable starts set [RQ12]
      top_reg  <= `HTC_RST_TOP;
      cmp_reg  <= `HTC_RST_CMP;
      irq_en   <= `HTC_RST_MASK;
      wake_en  <= `HTC_RST_MASK;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= reg_wdata;  // [RQ10]
      end
      if (wr_top) begin
        top_reg <= reg_wdata;  // Variable period [RQ8]
      end
      if (wr_cmp) begin
        cmp_reg <= reg_wdata;
      end
      if (wr_irqen) begin
        irq_en <= reg_wdata[2:0];  // [RQ17]
      end
      if (wr_wake) begin
        wake_en <= reg_wdata[2:0];
      end
    end
  end

  // ==========================================================
  // Sticky status; a new event wins over a clear in the same cycle
  wire [2:0] events = {cap_ev, tick & match, tick & ovf_ev};  // [RQ7]
  wire [2:0] clr    = wr_clr ? reg_wdata[2:0] : 3'h0;
  wire [2:0] next_status = (status & ~clr) | events;  // [RQ7]
  // A pin reset wins, so the interrupts drop in the same cycle as the flags
  wire [2:0] status_d    = pin_reset ? 3'h0 : next_status;

  always @(posedge ref_clk or negedge rst_s2) begin
    if (!rst_s2) begin
      status <= 3'h0;
    end else begin
      status <= status_d;  // Pin reset clears the flags [RQ11]
    end
  end

  // ==========================================================
  // Interrupt outputs, registered
  always @(posedge ref_clk or negedge rst_s2) begin
    if (!rst_s2) begin
      timer_irq <= 1'b0;
      wake_irq  <= 1'b0;
    end else begin
      if (bus_enable) begin
        timer_irq <= |(status_d & irq_en);  // [RQ5] [RQ17]
      end else begin
        timer_irq <= status_d[`HTC_ST_OVF];  // [RQ16]
      end
      // Stand-alone use wakes on overflow alone
      wake_irq <= bus_enable ? |(status_d & wake_en)
                             : status_d[`HTC_ST_OVF];  // [RQ6]
    end
  end

  // ==========================================================
  // Read data, valid in the cycle after the read strobe
  always @(posedge ref_clk or negedge rst_s2) begin
    if (!rst_s2) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `HTC_OFS_CTRL:   reg_rdata <= ctrl_eff;
        `HTC_OFS_TOP:    reg_rdata <= top_src;
        `HTC_OFS_CMP:    reg_rdata <= cmp_src;
        `HTC_OFS_COUNT:  reg_rdata <= count_value;
        `HTC_OFS_CAPT:   reg_rdata <= capture_register;
        `HTC_OFS_STAT:   reg_rdata <= {13'h0000, status};
        `HTC_OFS_IRQEN:  reg_rdata <= {13'h0000, irq_en};
        `HTC_OFS_WAKEEN: reg_rdata <= {13'h0000, wake_en};
        default:         reg_rdata <= 16'h0000;  // Unmapped and clear reg
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule

// file: tb/htc_top_chk.sv
`timescale 1ns/100ps
// ========
// Port checker: register port, masking, stand-alone flag
module htc_top_chk (
  // Clock and reset
  input wire        ref_clk,
  input wire        rst_n,
  // Register port
  input wire [3:0]  reg_addr,
  input wire [15:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [15:0] reg_rdata,
  // Mode and pins
  input wire        bus_enable,
  input wire        timer_reset_n_pin,
  // Results
  input wire        compare_output,
  input wire        timer_irq,
  input wire        wake_irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Bus write of an all-zero mask
  sequence s_mask(a);
    bus_enable && reg_wr && reg_addr == a && reg_wdata[2:0] == 3'h0;
  endsequence
  // Period or compare write, one idle cycle, read back of the same word
  sequence s_wr_rd;
    (bus_enable && reg_wr && (reg_addr == 4'h1 || reg_addr == 4'h2)) ##1 !reg_wr
    ##1 (reg_rd && reg_addr == $past(reg_addr, 2));
  endsequence
  property p_rd_idle;
    reg_rdata != 16'h0000 |-> $past(reg_rd);
  endproperty
  property p_rd_zero;
    reg_rd && (reg_addr == 4'h6 || reg_addr > 4'h8) |=> reg_rdata == 16'h0000;
  endproperty
  property p_readback;
    s_wr_rd |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  // Masks need two quiet cycles to reach the registered outputs
  property p_irq_mask;
    s_mask(4'h7) ##1 (bus_enable && !reg_wr)[*2] |=> !timer_irq;
  endproperty
  property p_wake_mask;
    s_mask(4'h8) ##1 (bus_enable && !reg_wr)[*2] |=> !wake_irq;
  endproperty
  property p_sa_same;
    (!bus_enable)[*4] |-> timer_irq == wake_irq;
  endproperty
  // Pin sync delay covered by six quiet cycles
  property p_sa_sticky;
    (!bus_enable && timer_reset_n_pin)[*6] ##0 timer_irq |=> timer_irq;
  endproperty
  property p_pin_clear;
    (!bus_enable && !timer_reset_n_pin)[*5] |-> !timer_irq && !compare_output;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  a_rd_zero: assert property (p_rd_zero) else $error("unmapped read not zero");
  a_readback: assert property (p_readback) else $error("register readback wrong");
  a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
  a_wake_mask: assert property (p_wake_mask) else $error("wake while masked");
  a_sa_same: assert property (p_sa_same) else $error("stand-alone flags differ");
  a_sa_sticky: assert property (p_sa_sticky) else $error("overflow flag lost");
  a_pin_clear: assert property (p_pin_clear) else $error("reset pin ignored");
endmodule

bind htc_top htc_top_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .bus_enable(bus_enable), .timer_reset_n_pin(timer_reset_n_pin),
  .compare_output(compare_output), .timer_irq(timer_irq), .wake_irq(wake_irq));

// file: tb/htc_bus_master.sv
`timescale 1ns/100ps
// ========
// Core-logic master on the register port
module htc_bus_master (
  // Clock
  input  wire         ref_clk,
  // Register port
  output logic [3:0]  reg_addr,
  output logic [15:0] reg_wdata,
  output logic        reg_wr,
  output logic        reg_rd,
  input  wire  [15:0] reg_rdata
);
  // Idle bus from time zero
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // One write cycle, strobe dropped at the taking edge
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Two reads gap cycles apart; data taken in the slot after each
  task automatic rd_pair(input logic [3:0] a, input int gap,
                         output logic [15:0] v0, output logic [15:0] v1);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= (gap == 1);
    @(posedge ref_clk);
    v0 = reg_rdata;
    if (gap > 1) begin
      repeat (gap - 2) @(posedge ref_clk);
      reg_rd <= 1'b1;
      @(posedge ref_clk);
    end
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    v1 = reg_rdata;
  endtask
endmodule

// file: tb/tb_top.sv
`timescale 1ns/100ps
`include "htc_map.vh"
// ========
// Self-checking bench for the timer block
module tb_top;
  // Clock, reset and pins
  logic        ref_clk;
  logic        rst_n;
  logic        bus_enable;
  logic        timer_clock_in;
  logic        timer_reset_n_pin;
  logic        capture_trigger;
  // Register port and results
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        compare_output;
  logic        timer_irq;
  logic        wake_irq;
  // Scoreboard and read scratch
  int          n_errors;
  int          compares;
  logic [15:0] v0;
  logic [15:0] v1;
  logic [15:0] w;

  // Short stand-alone period so the overflow flag shows quickly
  htc_top #(.PRELOAD_CTRL(16'h0701), .PRELOAD_TOP(16'h0007), .PRELOAD_CMP(16'h0003)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_enable(bus_enable),
    .timer_clock_in(timer_clock_in), .timer_reset_n_pin(timer_reset_n_pin),
    .capture_trigger(capture_trigger), .compare_output(compare_output),
    .timer_irq(timer_irq), .wake_irq(wake_irq));
  htc_bus_master m (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  always #5 ref_clk = ~ref_clk;

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Count and judge one comparison
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Stop, load period and compare, zero the count, then start
  task automatic cfg(input logic [15:0] top, input logic [15:0] cmp, input logic [15:0] ctl);
    m.wr(`HTC_OFS_CTRL, 16'h0000);
    m.wr(`HTC_OFS_TOP, top);
    m.wr(`HTC_OFS_CMP, cmp);
    m.rd_pair(`HTC_OFS_CMP, 1, v0, w);
    chk("cmp readback", cmp, v0);
    m.wr(`HTC_OFS_COUNT, 16'h0000);
    m.wr(`HTC_OFS_CTRL, ctl);
  endtask
  // Edges and high time over n cycles; seed sample keeps whole periods
  task automatic meas(input int n, output int r, output int h);
    logic p;
    r = 0;
    h = 0;
    @(posedge ref_clk);
    p = compare_output;
    repeat (n) begin
      @(posedge ref_clk);
      h += (compare_output === 1'b1);
      r += (compare_output === 1'b1 && p === 1'b0);
      p = compare_output;
    end
  endtask
  task automatic t_reset;
    logic [3:0]  a [8] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'h7, 4'h8, 4'hF};
    logic [15:0] e [8] = '{16'h0100, 16'hFFFF, 16'h8000, 16'h0000, 16'h0000, 16'h0000,
                           16'h0000, 16'h0000};
    for (int i = 0; i < 8; i++) begin
      m.rd_pair(a[i], 1, v0, w);
      chk("reset value", e[i], v0);
    end
  endtask
  // Clear-on-match and watchdog, both directions, three prescales
  task automatic t_count;
    logic [15:0] c [4] = '{16'h0201, 16'h0205, 16'h0210, 16'h0224};
    int g [4] = '{1, 1, 8, 64};
    int l [4] = '{5, 5, 65536, 65536};
    int s [4] = '{1, -1, 1, -1};
    for (int i = 0; i < 4; i++) begin
      cfg(16'h0004, 16'h8000, c[i]);
      idle(3);
      m.rd_pair(`HTC_OFS_COUNT, g[i], v0, v1);
      chk("count step", 16'((int'(v0) + s[i] + l[i]) % l[i]), v1);
    end
  endtask
  task automatic t_extclk;
    cfg(16'hFFFF, 16'h8000, 16'h0209);
    m.rd_pair(`HTC_OFS_COUNT, 1, v0, w);
    repeat (5) begin
      timer_clock_in <= 1'b1;
      idle(2);
      timer_clock_in <= 1'b0;
      idle(2);
    end
    m.rd_pair(`HTC_OFS_COUNT, 1, v1, w);
    chk("ext count", v0 + 16'h0005, v1);
  endtask
  task automatic t_irq;
    cfg(16'h0004, 16'h0002, 16'h0201);
    idle(20);
    m.rd_pair(`HTC_OFS_STAT, 1, v0, w);
    chk("status", 16'h0003, v0);
    m.wr(`HTC_OFS_IRQEN, 16'h0001);
    idle(2);
    chk("irq on", 16'h0001, {15'h0000, timer_irq});
    chk("wake off", 16'h0000, {15'h0000, wake_irq});
    m.wr(`HTC_OFS_WAKEEN, 16'h0002);
    idle(2);
    chk("wake on", 16'h0001, {15'h0000, wake_irq});
    m.wr(`HTC_OFS_IRQEN, 16'h0000);
    idle(2);
    m.wr(`HTC_OFS_WAKEEN, 16'h0000);
    idle(3);
    chk("irq masked", 16'h0000, {15'h0000, timer_irq});
    m.wr(`HTC_OFS_CTRL, 16'h0001);
    m.wr(`HTC_OFS_CLR, 16'h0007);
    m.wr(`HTC_OFS_IRQEN, 16'h0007);
    idle(3);
    chk("irq cleared", 16'h0000, {15'h0000, timer_irq});
  endtask
  task automatic pulse_cap;
    capture_trigger <= 1'b1;
    idle(3);
    capture_trigger <= 1'b0;
    idle(6);
  endtask
  // Capture on a frozen count, then refused in a PWM mode
  task automatic t_capture;
    m.wr(`HTC_OFS_COUNT, 16'h1234);
    m.wr(`HTC_OFS_CTRL, 16'h0080);
    pulse_cap;
    m.rd_pair(`HTC_OFS_CAPT, 1, v0, w);
    chk("capture", 16'h1234, v0);
    m.rd_pair(`HTC_OFS_STAT, 1, v0, w);
    chk("capture flag", 16'h0004, v0);
    chk("capture irq", 16'h0001, {15'h0000, timer_irq});
    m.wr(`HTC_OFS_CLR, 16'h0007);
    m.wr(`HTC_OFS_CTRL, 16'h0082);
    m.wr(`HTC_OFS_COUNT, 16'h0055);
    pulse_cap;
    m.rd_pair(`HTC_OFS_CAPT, 1, v0, v1);
    chk("pwm capture", 16'h1234, v0);
    m.rd_pair(`HTC_OFS_STAT, 1, v0, w);
    chk("pwm flag", 16'h0000, v0);
  endtask
  task automatic t_pwm;
    int r;
    int h0;
    int h1;
    cfg(16'h0009, 16'h0003, 16'h0202);
    idle(20);
    meas(100, r, h0);
    chk("fast period", 16'h000A, 16'(r));
    cfg(16'h0009, 16'h0003, 16'h0602);
    idle(20);
    meas(100, r, h1);
    chk("inverted duty", 16'h0064, 16'(h0 + h1));
    cfg(16'h0004, 16'h0002, 16'h0202);
    idle(20);
    meas(100, r, h0);
    chk("short period", 16'h0014, 16'(r));
    cfg(16'h0004, 16'h0002, 16'h0203);
    idle(20);
    meas(80, r, h0);
    chk("dual slope period", 16'h000A, 16'(r));
  endtask
  // Stand-alone: preloaded toggle mode, period of eight counts
  task automatic t_standalone;
    int r;
    int h;
    m.wr(`HTC_OFS_CTRL, 16'h0000);
    m.wr(`HTC_OFS_COUNT, 16'h0000);
    m.wr(`HTC_OFS_CLR, 16'h0007);
    bus_enable <= 1'b0;
    idle(30);
    chk("sa irq", 16'h0001, {15'h0000, timer_irq});
    chk("sa wake", 16'h0001, {15'h0000, wake_irq});
    timer_reset_n_pin <= 1'b0;
    idle(8);
    chk("pin irq", 16'h0000, {15'h0000, timer_irq});
    chk("pin output", 16'h0000, {15'h0000, compare_output});
    timer_reset_n_pin <= 1'b1;
    idle(30);
    chk("sa reload", 16'h0001, {15'h0000, timer_irq});
    meas(80, r, h);
    chk("sa toggle", 16'h0005, 16'(r));
    bus_enable <= 1'b1;
  endtask
  // Verdict and end of run
  task automatic tally_and_finish;
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Hang guard: run needs about a thousand cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    tally_and_finish;
  end
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    bus_enable = 1'b1;
    timer_clock_in = 1'b0;
    timer_reset_n_pin = 1'b1;
    capture_trigger = 1'b0;
    n_errors = 0;
    compares = 0;
    idle(10);
    rst_n <= 1'b1;
    idle(3);
    t_reset;
    t_count;
    t_extclk;
    t_irq;
    t_capture;
    t_pwm;
    t_standalone;
    tally_and_finish;
  end
endmodule
